// File: pkg/wkif_pkg.sv
// package: register map, field layout and reset values for wakeup flags
package wkif_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] WKIF_OFS_FLAGS   = 8'h00;
    localparam logic [7:0] WKIF_OFS_PINMODE = 8'h04;
    localparam logic [7:0] WKIF_OFS_TMRA    = 8'h08;
    localparam logic [7:0] WKIF_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] WKIF_OFS_ENABLE  = 8'h10;
    localparam logic [7:0] WKIF_OFS_CLEAR   = 8'h14;
    localparam logic [7:0] WKIF_OFS_TMRCNT  = 8'h18;
    // field positions
    localparam int WKIF_TMRA_FLAG_BIT = 0;
    localparam int WKIF_TMRA_RUN_BIT  = 1;
    localparam int WKIF_STS_WAKE_BIT  = 0;
    localparam int WKIF_STS_TMRA_BIT  = 1;
    localparam int WKIF_STS_W         = 2;
    // reset values and the timer wrap value
    localparam logic [7:0] WKIF_FLAGS_RST   = 8'h00;
    localparam logic [7:0] WKIF_PINMODE_RST = 8'h00;
    localparam logic [7:0] WKIF_TMR_MAX     = 8'hFF;
    localparam logic [7:0] WKIF_TMR_ZERO    = 8'h00;
    localparam logic [1:0] WKIF_STS_RST     = 2'h0;
endpackage

// File: design/wkif_edge_det.sv
// one wakeup pin: two-flop synchroniser and falling edge detector
`timescale 1ns/100ps
module wkif_edge_det (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic clkEn,
    // pin and result
    input  wire logic pinIn,
    output logic      fallPulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } wkif_edge_t;

    wkif_edge_t st_r;
    wkif_edge_t st_nxt;

    // shift the pin through; idle level of a pin is high
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pinIn;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '1;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // falling edge seen on the synchronised level
    assign fallPulse = clkEn & st_r.prev & ~st_r.s2;
endmodule

// File: design/wkif_top.sv
// wakeup interrupt request flags with timer a overflow flag and apb slave
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Contract
// RULE_01: eight wakeup flags, bits 7 to 0, all zero after reset
// RULE_02: flag n sets on falling edge of pin n in interrupt mode
// RULE_03: writing zero to a set flag clears it
// RULE_04: writes of one to request flags are ignored
// RULE_05: timer a flag sets when counter wraps from FF to 00
// RULE_06: hardware set wins over a same-cycle software clear
module wkif_top
    import wkif_pkg::*;
#(
    parameter int NPINS = 8
) (
    // clock, enable and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // wakeup pins, active low edges
    input  wire logic [NPINS-1:0]  wakeup_pin,
    // timer a count tick from the prescaler, same clock domain
    input  wire logic              tmrTick,
    // interrupt and flag outputs
    output logic                   irq,
    output logic      [NPINS-1:0]  wakeup_pin_flag,
    output logic                   tmraOvfFlag
);
    typedef struct packed {
        logic [NPINS-1:0] flags;
        logic [NPINS-1:0] pinMode;
        logic             tmraFlag;
        logic             tmraRun;
        logic [7:0]       tmrCnt;
        logic [1:0]       sts;
        logic [1:0]       ena;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
        logic             irq;
    } wkif_state_t;

    wkif_state_t st_r;
    wkif_state_t st_nxt;

    logic [NPINS-1:0] fallDet;
    logic             tmrWrap;
    logic             wrStb;
    logic             rdStb;
    logic             hit;
    logic [NPINS-1:0] setW_dbg;

    // one edge detector per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            wkif_edge_det u_edge (
                .ref_clk   (ref_clk),
                .arst_n    (arst_n),
                .clkEn     (clkEn),
                .pinIn     (wakeup_pin[gi]),
                .fallPulse (fallDet[gi])
            );
        end
    endgenerate

    // apb strobes, one-cycle answer in access phase
    assign wrStb = psel & penable & pwrite & ~st_r.ready & clkEn;
    assign rdStb = psel & penable & ~pwrite & ~st_r.ready & clkEn;
    assign hit   = (paddr == WKIF_OFS_FLAGS) | (paddr == WKIF_OFS_PINMODE)
                 | (paddr == WKIF_OFS_TMRA) | (paddr == WKIF_OFS_STATUS)
                 | (paddr == WKIF_OFS_ENABLE) | (paddr == WKIF_OFS_CLEAR)
                 | (paddr == WKIF_OFS_TMRCNT);
    assign tmrWrap = st_r.tmraRun & tmrTick & (st_r.tmrCnt == WKIF_TMR_MAX);
    // same set term as the flag logic, visible to the checks below
    assign setW_dbg = fallDet & st_r.pinMode;

    // next-state logic
    always_comb begin
        logic [NPINS-1:0] setW;
        logic [NPINS-1:0] clrW;
        logic             clrT;
        logic [1:0]       evt;
        logic [1:0]       clrS;
        setW   = '0;
        clrW   = '0;
        clrT   = 1'b0;
        evt    = '0;
        clrS   = '0;
        st_nxt = st_r;
        st_nxt.ready  = 1'b0;
        st_nxt.slverr = 1'b0;
        setW = fallDet & st_r.pinMode; // RULE_02
        // only zero bits clear; ones are dropped
        if (wrStb && paddr == WKIF_OFS_FLAGS) begin
            clrW = st_r.flags & ~pwdata[NPINS-1:0]; // RULE_03 RULE_04
        end
        if (wrStb && paddr == WKIF_OFS_TMRA) begin
            clrT = st_r.tmraFlag & ~pwdata[WKIF_TMRA_FLAG_BIT]; // RULE_03
            st_nxt.tmraRun = pwdata[WKIF_TMRA_RUN_BIT];
        end
        if (wrStb && paddr == WKIF_OFS_PINMODE) begin
            st_nxt.pinMode = pwdata[NPINS-1:0];
        end
        if (wrStb && paddr == WKIF_OFS_ENABLE) begin
            st_nxt.ena = pwdata[WKIF_STS_W-1:0];
        end
        if (wrStb && paddr == WKIF_OFS_CLEAR) begin
            clrS = pwdata[WKIF_STS_W-1:0];
        end
        // set after clear so a same-cycle event survives
        st_nxt.flags = (st_r.flags & ~clrW) | setW; // RULE_06
        if (st_r.tmraRun && tmrTick) begin
            st_nxt.tmrCnt = 8'(st_r.tmrCnt + 8'h01);
        end
        if (wrStb && paddr == WKIF_OFS_TMRCNT) begin
            st_nxt.tmrCnt = pwdata[7:0];
        end
        st_nxt.tmraFlag = (st_r.tmraFlag & ~clrT) | tmrWrap; // RULE_05
        // sticky status, set beats clear
        evt[WKIF_STS_WAKE_BIT] = |setW;
        evt[WKIF_STS_TMRA_BIT] = tmrWrap;
        st_nxt.sts = (st_r.sts & ~clrS) | evt;
        st_nxt.irq = |(st_nxt.sts & st_nxt.ena);
        // read mux and answer
        if (wrStb || rdStb) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = ~hit;
            st_nxt.rdata  = 32'h0000_0000;
            if (rdStb) begin
                case (paddr)
                    WKIF_OFS_FLAGS:   st_nxt.rdata[NPINS-1:0] = st_r.flags;
                    WKIF_OFS_PINMODE: st_nxt.rdata[NPINS-1:0] = st_r.pinMode;
                    WKIF_OFS_TMRA: begin
                        st_nxt.rdata[WKIF_TMRA_FLAG_BIT] = st_r.tmraFlag;
                        st_nxt.rdata[WKIF_TMRA_RUN_BIT]  = st_r.tmraRun;
                    end
                    WKIF_OFS_STATUS:  st_nxt.rdata[1:0] = st_r.sts;
                    WKIF_OFS_ENABLE:  st_nxt.rdata[1:0] = st_r.ena;
                    WKIF_OFS_TMRCNT:  st_nxt.rdata[7:0] = st_r.tmrCnt;
                    default:          st_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r          <= '0;
            st_r.flags    <= WKIF_FLAGS_RST; // RULE_01
            st_r.pinMode  <= WKIF_PINMODE_RST;
            st_r.tmrCnt   <= WKIF_TMR_ZERO;
            st_r.sts      <= WKIF_STS_RST;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign prdata          = st_r.rdata;
    assign pready          = st_r.ready;
    assign pslverr         = st_r.slverr;
    assign irq             = st_r.irq;
    assign wakeup_pin_flag = st_r.flags;
    assign tmraOvfFlag     = st_r.tmraFlag;

    // checks
    property p_rst_zero;
        @(posedge ref_clk) $rose(arst_n) |-> st_r.flags == WKIF_FLAGS_RST;
    endproperty
    a_rst_zero: assert property (p_rst_zero) // RULE_01
        else $error("flags not zero after reset");

    property p_set;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && fallDet[0] && st_r.pinMode[0]) |=> wakeup_pin_flag[0];
    endproperty
    a_set: assert property (p_set) // RULE_02
        else $error("wakeup flag 0 not set on edge");

    property p_noset_mask;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && !st_r.pinMode[1] && !st_r.flags[1]
         && !(wrStb && paddr == WKIF_OFS_FLAGS)) |=> !st_r.flags[1];
    endproperty
    a_noset_mask: assert property (p_noset_mask) // RULE_02
        else $error("flag 1 set while pin not interrupt input");

    property p_clr;
        @(posedge ref_clk) disable iff (!arst_n)
        (wrStb && paddr == WKIF_OFS_FLAGS && !pwdata[2] && !setW_dbg[2])
        |=> !wakeup_pin_flag[2];
    endproperty
    a_clr: assert property (p_clr) // RULE_03
        else $error("flag 2 not cleared by zero write");

    property p_noone;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && setW_dbg == '0) |=> (st_r.flags & ~$past(st_r.flags)) == '0;
    endproperty
    a_noone: assert property (p_noone) // RULE_04
        else $error("flag set without pin edge");

    property p_wrap;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && tmrWrap) |=> tmraOvfFlag && st_r.tmrCnt == WKIF_TMR_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) // RULE_05
        else $error("timer a overflow flag not set on wrap");

    property p_setwins;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && setW_dbg[3] && wrStb && paddr == WKIF_OFS_FLAGS)
        |=> wakeup_pin_flag[3];
    endproperty
    a_setwins: assert property (p_setwins) // RULE_06
        else $error("set lost to same-cycle clear");

    property p_irq;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && tmrWrap && st_r.ena[WKIF_STS_TMRA_BIT]) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq missing after enabled event");

    // apb answer timing
    property p_answer;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && psel && penable && !pready) |=> pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer one cycle into access phase");

    property p_ready_pulse;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && pready) |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");

    property p_err_with_ready;
        @(posedge ref_clk) disable iff (!arst_n)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!arst_n)
        (rdStb && !hit) |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    // clock enable low holds every register
    property p_freeze;
        @(posedge ref_clk) disable iff (!arst_n)
        !clkEn |=> $stable(st_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_tmr_clr;
        @(posedge ref_clk) disable iff (!arst_n)
        (wrStb && paddr == WKIF_OFS_TMRA && !pwdata[WKIF_TMRA_FLAG_BIT]
         && !tmrWrap) |=> !tmraOvfFlag;
    endproperty
    a_tmr_clr: assert property (p_tmr_clr) // RULE_03
        else $error("timer a flag not cleared by zero write");

    property p_tmr_keep;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && !tmrWrap && !tmraOvfFlag) |=> !tmraOvfFlag;
    endproperty
    a_tmr_keep: assert property (p_tmr_keep) // RULE_04
        else $error("timer a flag set without wrap");

    property p_sts_wake;
        @(posedge ref_clk) disable iff (!arst_n)
        (clkEn && |setW_dbg) |=> st_r.sts[WKIF_STS_WAKE_BIT];
    endproperty
    a_sts_wake: assert property (p_sts_wake) // RULE_06
        else $error("wakeup status lost to same-cycle clear");

    c_set:  cover property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(wakeup_pin_flag[0]));
    c_clr:  cover property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(wakeup_pin_flag[0]));
    c_wrap: cover property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(tmraOvfFlag));
    c_irq:  cover property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(irq));
endmodule

// File: verif/wkif_pin_model.sv
// far side model: wakeup pins with pull-ups and the timer count tick
`timescale 1ns/100ps
module wkif_pin_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // requests from the bench
    input  wire logic [7:0] fallReq,
    input  wire logic       tickReq,
    // pins toward the block
    output logic      [7:0] wakeup_pin,
    output logic            tmrTick
);
    logic [2:0] lowCnt_r;

    // pins idle high, a request pulls the masked pins low for six cycles
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeup_pin <= 8'hFF;
            lowCnt_r   <= 3'h0;
            tmrTick    <= 1'b0;
        end else begin
            tmrTick <= tickReq;
            if (fallReq != 8'h00) begin
                wakeup_pin <= ~fallReq;
                lowCnt_r   <= 3'h6;
            end else if (lowCnt_r != 3'h0) begin
                lowCnt_r <= lowCnt_r - 3'h1;
                if (lowCnt_r == 3'h1) begin
                    wakeup_pin <= 8'hFF;
                end
            end
        end
    end
endmodule

// File: verif/tb_wakeup_interrupt_flags.sv
// self-checking bench for the wakeup and timer request flags
`timescale 1ns/100ps
module tb_wakeup_interrupt_flags;
    import wkif_pkg::*;
    logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        irq, tmraOvfFlag, tmrTick, tickReq, er, clkEn;
    logic [7:0]  paddr, wakeup_pin, wakeup_pin_flag, fallReq;
    logic [31:0] pwdata, prdata, rd;
    int          errTotal, comparisons;

    wkif_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeup_pin(wakeup_pin), .tmrTick(tmrTick),
        .irq(irq), .wakeup_pin_flag(wakeup_pin_flag),
        .tmraOvfFlag(tmraOvfFlag));
    wkif_pin_model peer (.ref_clk(ref_clk), .arst_n(arst_n),
        .fallReq(fallReq), .tickReq(tickReq), .wakeup_pin(wakeup_pin),
        .tmrTick(tmrTick));

    // clock generation
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // answer and data taken at the rising edge that shows pready high
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            errTotal++;
            report_and_stop();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fall(input logic [7:0] m);
        @(posedge ref_clk) fallReq <= m;
        @(posedge ref_clk) fallReq <= 8'h00;
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        apb(1'b0, WKIF_OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0000);
        apb(1'b0, WKIF_OFS_PINMODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset values done");
    endtask

    task automatic t_pin_edges();
        apb(1'b1, WKIF_OFS_PINMODE, 32'h0000_000F);
        fall(8'hFF);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_000F);
        apb(1'b0, WKIF_OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_000F);
        apb(1'b0, WKIF_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        $display("test pin edges done");
    endtask

    task automatic t_write_clear();
        apb(1'b1, WKIF_OFS_FLAGS, 32'h0000_00FF);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_000F);
        apb(1'b1, WKIF_OFS_FLAGS, 32'h0000_0005);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0005);
        apb(1'b1, WKIF_OFS_FLAGS, 32'h0000_0000);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0000);
        apb(1'b1, WKIF_OFS_CLEAR, 32'h0000_0003);
        apb(1'b0, WKIF_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // pin 3 edge lands in the same cycle as a zero write
        apb(1'b1, WKIF_OFS_ENABLE, 32'h0000_0001);
        @(posedge ref_clk) fallReq <= 8'h08;
        @(posedge ref_clk) fallReq <= 8'h00;
        apb(1'b1, WKIF_OFS_FLAGS, 32'h0000_0000);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0000_0001);
        repeat (8) @(posedge ref_clk);
        apb(1'b1, WKIF_OFS_FLAGS, 32'h0000_0000);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0000);
        apb(1'b1, WKIF_OFS_CLEAR, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test write clear done");
    endtask

    task automatic t_timer_irq();
        apb(1'b1, WKIF_OFS_TMRCNT, 32'h0000_00FE);
        apb(1'b1, WKIF_OFS_TMRA, 32'h0000_0002);
        apb(1'b1, WKIF_OFS_ENABLE, 32'h0000_0002);
        chk({31'h0, tmraOvfFlag}, 32'h0000_0000);
        @(posedge ref_clk) tickReq <= 1'b1;
        repeat (2) @(posedge ref_clk);
        tickReq <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({31'h0, tmraOvfFlag}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, WKIF_OFS_TMRCNT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, WKIF_OFS_TMRA, 32'h0000_0003);
        chk({31'h0, tmraOvfFlag}, 32'h0000_0001);
        apb(1'b1, WKIF_OFS_TMRA, 32'h0000_0002);
        chk({31'h0, tmraOvfFlag}, 32'h0000_0000);
        apb(1'b1, WKIF_OFS_CLEAR, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        $display("test timer and irq done");
    endtask

    task automatic t_freeze();
        apb(1'b1, WKIF_OFS_TMRCNT, 32'h0000_0010);
        @(posedge ref_clk) clkEn <= 1'b0;
        tickReq <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tickReq <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clkEn <= 1'b1;
        apb(1'b0, WKIF_OFS_TMRCNT, 32'h0000_0000);
        chk(rd, 32'h0000_0010);
        @(posedge ref_clk) tickReq <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tickReq <= 1'b0;
        apb(1'b0, WKIF_OFS_TMRCNT, 32'h0000_0000);
        chk(rd, 32'h0000_0013);
        apb(1'b1, WKIF_OFS_TMRA, 32'h0000_0000);
        $display("test clock enable freeze done");
    endtask

    task automatic t_mid_reset();
        fall(8'h01);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0001);
        @(posedge ref_clk) arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        chk({24'h0, wakeup_pin_flag}, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b0, WKIF_OFS_PINMODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset in mid run done");
    endtask

    // main sequence
    initial begin
        errTotal = 0;
        comparisons = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fallReq = 8'h00;
        tickReq = 1'b0;
        clkEn = 1'b1;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_pin_edges();
        t_write_clear();
        t_timer_irq();
        t_freeze();
        t_mid_reset();
        report_and_stop();
    end
endmodule
